// >>> rtl/pvcr_defs.vh
// Purpose: constants for the vendor management register bank
// Assumes: 5-bit management register address, 16-bit data
// Notes:   offsets are management register addresses
`ifndef PVCR_DEFS_VH
`define PVCR_DEFS_VH

`define PVCR_ADDR_PORT_CFG     5'h10
`define PVCR_ADDR_SECOND_STAT  5'h11
`define PVCR_ADDR_STAT_CHANGE  5'h13
`define PVCR_ADDR_IND_CFG      5'h14
`define PVCR_ADDR_DIGITAL_CFG  5'h1A
`define PVCR_ADDR_TX_CTRL      5'h1E

`define PVCR_BIT_FORCE_LINK    14
`define PVCR_BIT_TX_DISABLE    13
`define PVCR_BIT_SCR_BYPASS    12
`define PVCR_BIT_JABBER_OFF    10
`define PVCR_BIT_HEARTBEAT     9
`define PVCR_BIT_ECHO_SUPP     8
`define PVCR_BIT_CARRIER_EXT   7
`define PVCR_BIT_PREAMBLE      5
`define PVCR_BIT_ALT_NP        1

`define PVCR_CFG_WMASK         16'h77A2
`define PVCR_CFG_RESET         16'h0080
`define PVCR_OTHER_RESET       16'h0000
`define PVCR_BASE_PAGE_BIT     5

`endif

// >>> rtl/pvcr_stat_latch.v
// Purpose: latching-high base-page and page-received flags
// Assumes: events and read strobes come from the management clock domain
// Notes:   a set in the clearing cycle wins over the clear
`timescale 1ns/1ps
module pvcr_stat_latch
(
  input  wire clock,
  input  wire reset,
  input  wire alt_np_enable,
  input  wire base_page_event,
  input  wire page_event,
  input  wire page_received_variable,
  input  wire transmit_disable,
  input  wire status_read,
  output reg  base_page_flag,
  output reg  page_received_flag,
  output wire base_page_report
);

  wire page_clear;

  assign page_clear = status_read |
                      (alt_np_enable & (~page_received_variable | transmit_disable));
  assign base_page_report = base_page_flag & alt_np_enable;

  always @(posedge clock)
  begin
    if (reset)
    begin
      base_page_flag     <= 1'b0;
      page_received_flag <= 1'b0;
    end
    else
    begin
      if (base_page_event)
        base_page_flag <= 1'b1;
      else if (status_read)
        base_page_flag <= 1'b0;
      if (page_event)
        page_received_flag <= 1'b1;
      else if (page_clear)
        page_received_flag <= 1'b0;
    end
  end

endmodule

// >>> rtl/pvcr_regs.v
// Purpose: vendor management registers 16..31 and port configuration controls
// Assumes: management frame logic delivers one-cycle read/write strobes
// Notes:   line-side inputs are synchronised before use
`timescale 1ns/1ps
`include "pvcr_defs.vh"
module pvcr_regs
(
  input  wire        clock,
  input  wire        reset,
  input  wire [4:0]  mgmt_addr,
  input  wire [15:0] mgmt_wdata,
  input  wire        mgmt_write,
  input  wire        mgmt_read,
  output reg  [15:0] mgmt_rdata,
  output reg         mgmt_reserved,
  input  wire [15:0] second_status_in,
  input  wire [15:0] status_change_in,
  output wire        status_change_read,
  input  wire        speed_100,
  input  wire        link_detect,
  input  wire        carrier_raw,
  input  wire        frame_delim,
  input  wire        receive_end,
  input  wire        base_page_event,
  input  wire        page_event,
  input  wire        page_received_variable,
  output reg         link_pass,
  output reg         tx_disable,
  output reg         scrambler_bypass,
  output reg         jabber_correct_off,
  output reg         heartbeat_test_enable,
  output reg         twisted_pair_echo_suppress,
  output reg         carrier_extend_select,
  output reg         alternate_next_page_enable,
  output reg         carrier_sense,
  output reg         receive_valid,
  output reg         preamble_pass,
  output wire        base_page_report,
  output wire        page_received_flag
);

  // ****************************************
  // state
  // ****************************************
  reg  [15:0] port_configuration;
  reg  [15:0] indicator_configuration;
  reg  [15:0] digital_configuration;
  reg  [15:0] transmit_control;
  reg  [1:0]  speed_sync;
  reg  [1:0]  link_sync;
  reg  [1:0]  crs_sync;
  reg  [1:0]  sfd_sync;
  reg  [1:0]  rend_sync;
  reg         rx_active;
  wire        base_page_flag;
  wire        speed_s;
  wire        link_s;
  wire        crs_s;
  wire        sfd_s;
  wire        rend_s;
  wire        preamble_on;
  wire        extend_on;
  wire        next_receive_valid;
  wire        next_carrier_sense;
  wire        cfg_read;

  function is_reserved;
    input [4:0] a;
    begin
      case (a)
        `PVCR_ADDR_PORT_CFG,
        `PVCR_ADDR_SECOND_STAT,
        `PVCR_ADDR_STAT_CHANGE,
        `PVCR_ADDR_IND_CFG,
        `PVCR_ADDR_DIGITAL_CFG,
        `PVCR_ADDR_TX_CTRL: is_reserved = 1'b0;
        default:            is_reserved = 1'b1;
      endcase
    end
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  always @(posedge clock)
  begin
    if (reset)
    begin
      speed_sync <= 2'h0;
      link_sync  <= 2'h0;
      crs_sync   <= 2'h0;
      sfd_sync   <= 2'h0;
      rend_sync  <= 2'h0;
    end
    else
    begin
      speed_sync <= {speed_sync[0], speed_100};
      link_sync  <= {link_sync[0], link_detect};
      crs_sync   <= {crs_sync[0], carrier_raw};
      sfd_sync   <= {sfd_sync[0], frame_delim};
      rend_sync  <= {rend_sync[0], receive_end};
    end
  end

  assign speed_s = speed_sync[1];
  assign link_s  = link_sync[1];
  assign crs_s   = crs_sync[1];
  assign sfd_s   = sfd_sync[1];
  assign rend_s  = rend_sync[1];

  // ****************************************
  // register writes
  // ****************************************
  // reserved port configuration bits are masked so they always read 0, whatever is written
  always @(posedge clock)
  begin
    if (reset)
    begin
      port_configuration      <= `PVCR_CFG_RESET;
      indicator_configuration <= `PVCR_OTHER_RESET;
      digital_configuration   <= `PVCR_OTHER_RESET;
      transmit_control        <= `PVCR_OTHER_RESET;
    end
    else if (mgmt_write)
    begin
      case (mgmt_addr)
        `PVCR_ADDR_PORT_CFG:
          port_configuration <= mgmt_wdata & `PVCR_CFG_WMASK;
        `PVCR_ADDR_IND_CFG:
          indicator_configuration <= mgmt_wdata;
        `PVCR_ADDR_DIGITAL_CFG:
          digital_configuration <= mgmt_wdata;
        `PVCR_ADDR_TX_CTRL:
          transmit_control <= mgmt_wdata;
        default:
          port_configuration <= port_configuration;
      endcase
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  assign cfg_read           = mgmt_read & (mgmt_addr == `PVCR_ADDR_PORT_CFG);
  assign status_change_read = mgmt_read & (mgmt_addr == `PVCR_ADDR_STAT_CHANGE);

  always @(posedge clock)
  begin
    if (reset)
    begin
      mgmt_rdata    <= 16'h0000;
      mgmt_reserved <= 1'b0;
    end
    else if (mgmt_read)
    begin
      mgmt_reserved <= is_reserved(mgmt_addr);
      case (mgmt_addr)
        `PVCR_ADDR_PORT_CFG:     mgmt_rdata <= port_configuration;
        `PVCR_ADDR_SECOND_STAT:  mgmt_rdata <= second_status_in;
        `PVCR_ADDR_STAT_CHANGE:  mgmt_rdata <= status_change_in;
        `PVCR_ADDR_IND_CFG:      mgmt_rdata <= indicator_configuration;
        `PVCR_ADDR_DIGITAL_CFG:  mgmt_rdata <= digital_configuration;
        `PVCR_ADDR_TX_CTRL:      mgmt_rdata <= transmit_control;
        default:                 mgmt_rdata <= 16'h0000;
      endcase
    end
  end

  // ****************************************
  // configuration controls
  // ****************************************
  always @(posedge clock)
  begin
    if (reset)
    begin
      link_pass                  <= 1'b0;
      tx_disable                 <= 1'b0;
      scrambler_bypass           <= 1'b0;
      jabber_correct_off         <= 1'b0;
      heartbeat_test_enable      <= 1'b0;
      twisted_pair_echo_suppress <= 1'b0;
      carrier_extend_select      <= 1'b1;
      alternate_next_page_enable <= 1'b0;
    end
    else
    begin
      link_pass  <= port_configuration[`PVCR_BIT_FORCE_LINK] | link_s;
      tx_disable <= port_configuration[`PVCR_BIT_TX_DISABLE];
      scrambler_bypass <= port_configuration[`PVCR_BIT_SCR_BYPASS] & speed_s;
      jabber_correct_off <= port_configuration[`PVCR_BIT_JABBER_OFF] & ~speed_s;
      heartbeat_test_enable <= port_configuration[`PVCR_BIT_HEARTBEAT] & ~speed_s;
      twisted_pair_echo_suppress <=
        port_configuration[`PVCR_BIT_ECHO_SUPP] & ~speed_s;
      carrier_extend_select <= port_configuration[`PVCR_BIT_CARRIER_EXT] & ~speed_s;
      alternate_next_page_enable <= port_configuration[`PVCR_BIT_ALT_NP];
    end
  end

  // ****************************************
  // receive valid and carrier timing
  // ****************************************
  assign preamble_on = speed_s | port_configuration[`PVCR_BIT_PREAMBLE];
  assign extend_on   = ~speed_s & port_configuration[`PVCR_BIT_CARRIER_EXT];

  // frame end from the line always closes the frame, even if carrier dropped earlier
  assign next_receive_valid = rend_s ? 1'b0 :
                              rx_active ? 1'b1 :
                              preamble_on ? crs_s :
                              sfd_s;
  assign next_carrier_sense = crs_s | (extend_on & next_receive_valid);

  always @(posedge clock)
  begin
    if (reset)
    begin
      rx_active     <= 1'b0;
      receive_valid <= 1'b0;
      carrier_sense <= 1'b0;
      preamble_pass <= 1'b0;
    end
    else
    begin
      rx_active     <= next_receive_valid;
      receive_valid <= next_receive_valid;
      carrier_sense <= next_carrier_sense;
      preamble_pass <= preamble_on & crs_s & ~rx_active;
    end
  end

  // ****************************************
  // expansion status flags
  // ****************************************
  pvcr_stat_latch u_stat_latch
  (
    .clock                  (clock),
    .reset                  (reset),
    .alt_np_enable          (port_configuration[`PVCR_BIT_ALT_NP]),
    .base_page_event        (base_page_event),
    .page_event             (page_event),
    .page_received_variable (page_received_variable),
    .transmit_disable       (port_configuration[`PVCR_BIT_TX_DISABLE]),
    .status_read            (status_change_read),
    .base_page_flag         (base_page_flag),
    .page_received_flag     (page_received_flag),
    .base_page_report       (base_page_report)
  );

endmodule

// >>> tb/pvcr_mgmt_model.sv
// Purpose: management station model issuing register reads and writes
// Assumes: one-cycle strobes, read data valid one cycle after the read edge
// Notes:   reserved port configuration bits always leave as zero
`timescale 1ns/1ps
`include "pvcr_defs.vh"
module pvcr_mgmt_model
(
  input  wire        clock,
  output reg  [4:0]  addr,
  output reg  [15:0] wdata,
  output reg         wr,
  output reg         rd,
  input  wire [15:0] rdata
);
  // ********************
  // frame tasks
  // ********************
  initial
  begin
    addr = 5'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  task wr16(input [4:0] a, input [15:0] d);
  begin
    @(posedge clock);
    addr <= a;
    wdata <= (a == `PVCR_ADDR_PORT_CFG) ? (d & `PVCR_CFG_WMASK) : d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  end
  endtask
  task rd16(input [4:0] a, output [15:0] d);
  begin
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
    #1 d = rdata;
  end
  endtask
endmodule

// >>> tb/pvcr_regs_checker.sv
// Purpose: port-level assertions for the vendor register bank
// Assumes: single clock domain, synchronous reset
// Notes:   control outputs lag a write by two edges
`timescale 1ns/1ps
module pvcr_regs_checker
(
  input wire        clock,
  input wire        reset,
  input wire [4:0]  mgmt_addr,
  input wire [15:0] mgmt_wdata,
  input wire        mgmt_write,
  input wire        mgmt_read,
  input wire [15:0] mgmt_rdata,
  input wire        mgmt_reserved,
  input wire [15:0] second_status_in,
  input wire        status_change_read,
  input wire        base_page_event,
  input wire        base_page_report,
  input wire        page_event,
  input wire        page_received_flag,
  input wire        link_pass,
  input wire        tx_disable,
  input wire        carrier_extend_select,
  input wire        alternate_next_page_enable
);
  // ********************
  // properties
  // ********************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  wire cfg_wr = mgmt_write && (mgmt_addr == 5'h10);
  property p_tx; cfg_wr |-> ##2 tx_disable == $past(mgmt_wdata[13], 2); endproperty
  a_tx: assert property (p_tx) else $error("tx disable mismatch");
  property p_lp; cfg_wr && mgmt_wdata[14] |-> ##2 link_pass; endproperty
  a_lp: assert property (p_lp) else $error("link pass not forced");
  property p_np;
    cfg_wr |-> ##2 alternate_next_page_enable == $past(mgmt_wdata[1], 2);
  endproperty
  a_np: assert property (p_np) else $error("next page enable mismatch");
  property p_rst; $past(reset) |-> carrier_extend_select && !tx_disable && !link_pass; endproperty
  a_rst: assert property (p_rst) else $error("bad reset outputs");
  property p_rsv;
    mgmt_read |=> mgmt_reserved != ($past(mgmt_addr) inside {5'h10, 5'h11, 5'h13, 5'h14, 5'h1A,
      5'h1E});
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved flag wrong");
  property p_st2;
    mgmt_read && mgmt_addr == 5'h11 |=> mgmt_rdata == $past(second_status_in);
  endproperty
  a_st2: assert property (p_st2) else $error("status read wrong");
  property p_scr; status_change_read == (mgmt_read && mgmt_addr == 5'h13); endproperty
  a_scr: assert property (p_scr) else $error("status change strobe wrong");
  property p_hold; !mgmt_read |=> $stable(mgmt_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_bpr; base_page_report |-> ##1 alternate_next_page_enable; endproperty
  a_bpr: assert property (p_bpr) else $error("base page shown while off");
  property p_bps;
    (base_page_event && !mgmt_write) ##1 alternate_next_page_enable |-> base_page_report;
  endproperty
  a_bps: assert property (p_bps) else $error("base page not latched");
  property p_prc; status_change_read && !page_event |=> !page_received_flag; endproperty
  a_prc: assert property (p_prc) else $error("page flag not cleared");
endmodule
bind pvcr_regs pvcr_regs_checker i_chk (.clock(clock), .reset(reset), .mgmt_addr(mgmt_addr),
  .mgmt_wdata(mgmt_wdata), .mgmt_write(mgmt_write), .mgmt_read(mgmt_read),
  .mgmt_rdata(mgmt_rdata), .mgmt_reserved(mgmt_reserved), .second_status_in(second_status_in),
  .status_change_read(status_change_read), .base_page_event(base_page_event),
  .base_page_report(base_page_report), .page_event(page_event),
  .page_received_flag(page_received_flag), .link_pass(link_pass), .tx_disable(tx_disable),
  .carrier_extend_select(carrier_extend_select),
  .alternate_next_page_enable(alternate_next_page_enable));

// >>> tb/pvcr_regs_bench.sv
// Purpose: self-checking bench for the vendor register bank
// Assumes: management model drives the register strobes
// Notes:   link detect held low so link pass shows only the config bit
`timescale 1ns/1ps
`include "pvcr_defs.vh"
module pvcr_regs_bench;
  reg         clock, reset, spd, link, crs, sfd, rend, bpe, pge, pgv;
  reg  [15:0] ssi, sci, d, r;
  wire [4:0]  a;
  wire [15:0] wd, rdat;
  wire        wr, rd, rsv, scrd, lp, txd, sb, jo, hb, es, ce, an, cs, rv, pp, bpr, prf;
  integer     failures, n_tests, cyc, i;
  pvcr_mgmt_model m (.clock(clock), .addr(a), .wdata(wd), .wr(wr), .rd(rd), .rdata(rdat));
  pvcr_regs i_dut (.clock(clock), .reset(reset), .mgmt_addr(a), .mgmt_wdata(wd),
    .mgmt_write(wr), .mgmt_read(rd), .mgmt_rdata(rdat), .mgmt_reserved(rsv),
    .second_status_in(ssi), .status_change_in(sci), .status_change_read(scrd),
    .speed_100(spd), .link_detect(link), .carrier_raw(crs), .frame_delim(sfd),
    .receive_end(rend), .base_page_event(bpe), .page_event(pge),
    .page_received_variable(pgv), .link_pass(lp), .tx_disable(txd),
    .scrambler_bypass(sb), .jabber_correct_off(jo), .heartbeat_test_enable(hb),
    .twisted_pair_echo_suppress(es), .carrier_extend_select(ce),
    .alternate_next_page_enable(an), .carrier_sense(cs), .receive_valid(rv),
    .preamble_pass(pp), .base_page_report(bpr), .page_received_flag(prf));
  // ********************
  // helpers
  // ********************
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // mode-gated bits read as off in the other speed
  function [15:0] ctl(input [15:0] c, input s);
    ctl = {8'h00, c[14], c[13], s & c[12], ~s & c[10], ~s & c[9], ~s & c[8], ~s & c[7], c[1]};
  endfunction
  task check(input [15:0] seen, input [15:0] exp);
  begin
    n_tests = n_tests + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  end
  endtask
  task finish_test;
  begin
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures = failures + 1;
      finish_test;
    end
  end
  // ********************
  // scenarios
  // ********************
  initial
  begin
    {reset, spd, link, crs, sfd, rend, bpe, pge, pgv} = 9'h100;
    {ssi, sci} = 32'h0000_0000;
    failures = 0;
    n_tests = 0;
    cyc = 0;
    void'($urandom(32'h4E6D));
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    m.rd16(5'h10, r);
    check(r, `PVCR_CFG_RESET);
    check({8'h00, lp, txd, sb, jo, hb, es, ce, an}, ctl(`PVCR_CFG_RESET, 1'b0));
    for (i = 0; i < 16; i = i + 1)
    begin
      @(posedge clock) spd <= i[0];
      d = (i < 2) ? {16{i[0]}} : $urandom;
      m.wr16(5'h10, d);
      repeat (4) @(posedge clock);
      #1 check({8'h00, lp, txd, sb, jo, hb, es, ce, an},
        ctl(d & `PVCR_CFG_WMASK, i[0]));
      m.rd16(5'h10, r);
      check(r & `PVCR_CFG_WMASK, d & `PVCR_CFG_WMASK);
    end
    for (i = 0; i < 32; i = i + 1)
    begin
      @(posedge clock) {ssi, sci} <= $urandom;
      m.rd16(i[4:0], r);
      check({15'h0, rsv}, {15'h0, !(i == 16 || i == 17 || i == 19 ||
        i == 20 || i == 26 || i == 30)});
      if (i == 17 || i == 19)
        check(r, (i == 17) ? ssi : sci);
    end
    // one frame per mode: 10M plain, 10M preamble, 100M
    for (i = 0; i < 3; i = i + 1)
    begin
      @(posedge clock) spd <= (i == 2);
      m.wr16(5'h10, (i == 1) ? 16'h00A0 : 16'h0080);
      @(posedge clock) crs <= 1'b1;
      // preamble marker is a one-cycle pulse, three edges after carrier rises
      repeat (3) @(posedge clock);
      #1 check({15'h0, pp}, {15'h0, i != 0});
      @(posedge clock);
      #1 check({15'h0, rv}, {15'h0, i != 0});
      @(posedge clock) sfd <= 1'b1;
      @(posedge clock) {sfd, crs} <= 2'b00;
      repeat (4) @(posedge clock);
      #1 check({14'h0, rv, cs}, {14'h0, 1'b1, i != 2});
      @(posedge clock) rend <= 1'b1;
      @(posedge clock) rend <= 1'b0;
      repeat (4) @(posedge clock);
      #1 check({14'h0, rv, cs}, 16'h0000);
    end
    @(posedge clock) pgv <= 1'b1;
    m.wr16(5'h10, 16'h0082);
    repeat (2) @(posedge clock);
    @(posedge clock) {bpe, pge} <= 2'b11;
    @(posedge clock) {bpe, pge} <= 2'b00;
    repeat (2) @(posedge clock);
    #1 check({14'h0, bpr, prf}, 16'h0003);
    @(posedge clock) pgv <= 1'b0;
    repeat (3) @(posedge clock);
    #1 check({15'h0, prf}, 16'h0000);
    m.wr16(5'h10, 16'h0080);
    repeat (2) @(posedge clock);
    #1 check({15'h0, bpr}, 16'h0000);
    finish_test;
  end
endmodule
